// >>> core/mss_pkg.sv
// package: shared constants and types for the module shutdown sequencer
// Overview of operation
// - soft shutdown: finalize, then monitor low
// - host never assumes fixed finalization time
// - monitor high while on, low when off
// - host holds toggle low 2.5 s minimum
// - toggle low beyond 2.5 s starts finalization
// - host waits for monitor fall, no bound
// - host holds kill low 200 ms minimum
// - host only pulls kill low or releases
// - kill path present, emergency use only
// - hard shutdown, wait monitor low, cut supply
// - host assigns trigger gpio before fast use
// - gpio falling edge: off within 30 ms; device ignores it in MSS_DETACH and MSS_FINAL
// - aux supply output low once off
// - fast power-down command also starts it; also ignored in MSS_DETACH and MSS_FINAL
// - detach request sent before soft/hard off
package mss_pkg;
  localparam int unsigned CLK_HZ          = 250_000_000;
  localparam int unsigned TOGGLE_MIN_MS   = 2500;
  localparam int unsigned KILL_MIN_MS     = 200;
  localparam int unsigned FAST_MAX_MS     = 30;
  localparam int unsigned FINAL_TYP_MS    = 10000;
  localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
  // least times round up, longest rounds down (exact at this rate)
  localparam int unsigned TOGGLE_MIN_CYC  = TOGGLE_MIN_MS * CYC_PER_MS;
  localparam int unsigned KILL_MIN_CYC    = KILL_MIN_MS * CYC_PER_MS;
  localparam int unsigned FAST_MAX_CYC    = FAST_MAX_MS * CYC_PER_MS;
  localparam int unsigned FINAL_TYP_CYC   = FINAL_TYP_MS * CYC_PER_MS;
  localparam int unsigned CNT_W           = 32;
  localparam logic        MON_RST         = 1'b0;
  typedef enum logic [2:0] {
    MSS_OFF, MSS_ON, MSS_DETACH, MSS_FINAL, MSS_FAST
  } mss_state_t;
endpackage

// >>> core/mss_if.sv
// interface: control pins between host and module
`timescale 1ns/1ps
interface mss_if;
  logic toggle_o;
  logic toggle_oe_n;
  logic hard_kill_o;
  logic hard_kill_n_oe_n;
  logic toggle_n_i;
  logic hard_kill_n_i;
  logic trig_gpio;
  logic power_monitor_out;
  logic aux_supply_out;
  logic detach_req;
  modport dev (
    input  toggle_n_i, hard_kill_n_i, trig_gpio,
    output power_monitor_out, aux_supply_out, detach_req
  );
  modport host (
    output toggle_o, toggle_oe_n, hard_kill_o, hard_kill_n_oe_n, trig_gpio,
    input  power_monitor_out, aux_supply_out
  );
  // open-collector wires: low while enable is low, else pulled up
  assign toggle_n_i    = toggle_oe_n ? 1'b1 : toggle_o;
  assign hard_kill_n_i = hard_kill_n_oe_n ? 1'b1 : hard_kill_o;
endinterface

// >>> core/mss_device.sv
// module end: shutdown sequencing of the device
`timescale 1ns/1ps
module mss_device #(
  parameter int unsigned TOGGLE_CYC = mss_pkg::TOGGLE_MIN_CYC,
  parameter int unsigned KILL_CYC   = mss_pkg::KILL_MIN_CYC,
  parameter int unsigned FAST_CYC   = mss_pkg::FAST_MAX_CYC,
  parameter int unsigned DETACH_CYC = 16
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // pins
  mss_if.dev        pins,
  // user side
  input  wire logic power_on,
  input  wire logic soft_shdn_cmd,
  input  wire logic fast_power_down_cmd,
  input  wire logic fast_trig_en,
  input  wire logic final_done,
  output logic      finalizing,
  output logic      detach_sent
);
  localparam int W = mss_pkg::CNT_W;
  logic [1:0] tog_s_reg, kill_s_reg, gpio_s_reg;
  logic       gpio_d_reg;
  logic [W-1:0] tog_cnt_reg, kill_cnt_reg, cnt_reg;
  mss_pkg::mss_state_t st_reg, st_next;
  logic mon_reg, aux_reg, det_reg, fin_reg, dsent_reg;

  wire tog_low   = ~tog_s_reg[1];
  wire kill_low  = ~kill_s_reg[1];
  wire gpio_fall = gpio_d_reg & ~gpio_s_reg[1] & fast_trig_en;
  wire tog_long  = tog_cnt_reg >= W'(TOGGLE_CYC);
  wire kill_long = kill_cnt_reg >= W'(KILL_CYC);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tog_s_reg  <= 2'h3;
      kill_s_reg <= 2'h3;
      gpio_s_reg <= 2'h3;
      gpio_d_reg <= 1'b1;
    end else begin
      tog_s_reg  <= {tog_s_reg[0], pins.toggle_n_i};
      kill_s_reg <= {kill_s_reg[0], pins.hard_kill_n_i};
      gpio_s_reg <= {gpio_s_reg[0], pins.trig_gpio};
      gpio_d_reg <= gpio_s_reg[1];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || !tog_low) tog_cnt_reg <= '0;
    else if (!tog_long) tog_cnt_reg <= tog_cnt_reg + W'(1);
    if (sys_rst || !kill_low) kill_cnt_reg <= '0;
    else if (!kill_long) kill_cnt_reg <= kill_cnt_reg + W'(1);
  end

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      mss_pkg::MSS_OFF:
        if (power_on) st_next = mss_pkg::MSS_ON;
      mss_pkg::MSS_ON:
        if (gpio_fall || fast_power_down_cmd) st_next = mss_pkg::MSS_FAST;
        else if (soft_shdn_cmd || tog_long) st_next = mss_pkg::MSS_DETACH;
      mss_pkg::MSS_DETACH:
        if (cnt_reg >= W'(DETACH_CYC)) st_next = mss_pkg::MSS_FINAL;
      mss_pkg::MSS_FINAL:
        if (final_done) st_next = mss_pkg::MSS_OFF;
      mss_pkg::MSS_FAST:
        if (cnt_reg >= W'(FAST_CYC - 1)) st_next = mss_pkg::MSS_OFF;
      default: st_next = mss_pkg::MSS_OFF;
    endcase
    if (kill_long && st_reg != mss_pkg::MSS_OFF) st_next = mss_pkg::MSS_OFF;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_reg    <= mss_pkg::MSS_OFF;
      cnt_reg   <= '0;
      mon_reg   <= mss_pkg::MON_RST;
      aux_reg   <= mss_pkg::MON_RST;
      det_reg   <= 1'b0;
      fin_reg   <= 1'b0;
      dsent_reg <= 1'b0;
    end else begin
      st_reg  <= st_next;
      cnt_reg <= (st_next == st_reg) ? cnt_reg + W'(1) : '0;
      mon_reg <= st_next != mss_pkg::MSS_OFF;
      aux_reg <= st_next != mss_pkg::MSS_OFF;
      det_reg <= st_next == mss_pkg::MSS_DETACH && st_reg != mss_pkg::MSS_DETACH;
      fin_reg <= st_next == mss_pkg::MSS_FINAL;
      if (st_next == mss_pkg::MSS_DETACH) dsent_reg <= 1'b1;
      else if (st_next == mss_pkg::MSS_ON) dsent_reg <= 1'b0;
    end
  end

  assign pins.power_monitor_out = mon_reg;
  assign pins.aux_supply_out    = aux_reg;
  assign pins.detach_req        = det_reg;
  assign finalizing             = fin_reg;
  assign detach_sent            = dsent_reg;
endmodule // mss_device

// >>> core/mss_host.sv
// host end: drives open-collector pins and watches power monitor
`timescale 1ns/1ps
module mss_host #(
  parameter int unsigned TOGGLE_CYC = mss_pkg::TOGGLE_MIN_CYC,
  parameter int unsigned KILL_CYC   = mss_pkg::KILL_MIN_CYC
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // pins
  mss_if.host       pins,
  // user side
  input  wire logic req_hard,
  input  wire logic req_kill,
  input  wire logic fast_trig,
  output logic      busy,
  output logic      module_off
);
  localparam int W = mss_pkg::CNT_W;
  logic [1:0] mon_s_reg, aux_s_reg;
  logic [W-1:0] tog_cnt_reg, kill_cnt_reg;
  logic tog_oe_n_reg, kill_oe_n_reg, wait_reg, gpio_reg, off_reg;

  wire mon_hi = mon_s_reg[1];
  // no new request while shutting down
  wire start_hard = req_hard && !wait_reg && tog_oe_n_reg && mon_hi;
  // kill only on explicit emergency request
  wire start_kill = req_kill && kill_oe_n_reg;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mon_s_reg     <= 2'h0;
      aux_s_reg     <= 2'h0;
      tog_oe_n_reg  <= 1'b1;
      kill_oe_n_reg <= 1'b1;
      tog_cnt_reg   <= '0;
      kill_cnt_reg  <= '0;
      wait_reg      <= 1'b0;
      gpio_reg      <= 1'b1;
      off_reg       <= 1'b0;
    end else begin
      mon_s_reg <= {mon_s_reg[0], pins.power_monitor_out};
      aux_s_reg <= {aux_s_reg[0], pins.aux_supply_out};
      if (start_hard) begin
        tog_oe_n_reg <= 1'b0;
        tog_cnt_reg  <= '0;
      end else if (!tog_oe_n_reg) begin
        tog_cnt_reg <= tog_cnt_reg + W'(1);
        if (tog_cnt_reg >= W'(TOGGLE_CYC)) begin
          tog_oe_n_reg <= 1'b1;
          wait_reg     <= 1'b1;
        end
      end
      if (start_kill) begin
        kill_oe_n_reg <= 1'b0;
        kill_cnt_reg  <= '0;
      end else if (!kill_oe_n_reg) begin
        kill_cnt_reg <= kill_cnt_reg + W'(1);
        if (kill_cnt_reg >= W'(KILL_CYC)) kill_oe_n_reg <= 1'b1;
      end
      // wait on monitor fall, no timeout
      if (wait_reg && !mon_hi) wait_reg <= 1'b0;
      // trigger gpio idles high, falls on request
      gpio_reg <= !fast_trig;
      // supply may be cut once off
      off_reg <= !mon_hi && !aux_s_reg[1];
    end
  end

  // toggle and kill pins only pulled low or released
  assign pins.toggle_o         = 1'b0;
  assign pins.hard_kill_o      = 1'b0;
  assign pins.toggle_oe_n      = tog_oe_n_reg;
  assign pins.hard_kill_n_oe_n = kill_oe_n_reg;
  assign pins.trig_gpio        = gpio_reg;
  assign busy                  = wait_reg;
  assign module_off            = off_reg;
endmodule // mss_host

// >>> sim/mss_asserts.sv
// checker: pin timing between host and device ends
`timescale 1ns/1ps
module mss_asserts #(
  parameter int TOGGLE_CYC = 50,
  parameter int KILL_CYC   = 20
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // host pins
  input wire logic toggle_oe_n,
  input wire logic hard_kill_o,
  input wire logic hard_kill_n_oe_n,
  input wire logic trig_gpio,
  // device pins
  input wire logic power_monitor_out,
  input wire logic aux_supply_out,
  input wire logic detach_req,
  // configuration
  input wire logic fast_trig_en
);
  localparam int T_HI = TOGGLE_CYC + 8;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  int t_reg;
  int k_reg;
  always_ff @(posedge sys_clk) begin
    t_reg <= (sys_rst || toggle_oe_n) ? 0 : t_reg + 1;
    k_reg <= (sys_rst || hard_kill_n_oe_n) ? 0 : k_reg + 1;
  end
  toggle_hold_a: assert property ($rose(toggle_oe_n) |-> t_reg >= TOGGLE_CYC)
    else $error("toggle short");
  kill_hold_a: assert property ($rose(hard_kill_n_oe_n) |-> k_reg >= KILL_CYC)
    else $error("kill short");
  kill_drive_a: assert property (!hard_kill_o)
    else $error("kill driven high");
  mon_aux_a: assert property (power_monitor_out == aux_supply_out)
    else $error("monitor and aux differ");
  fast_off_a: assert property ($fell(trig_gpio) && fast_trig_en && power_monitor_out |-> ##[1:36] !aux_supply_out)
    else $error("fast off late");
  toggle_start_a: assert property ($fell(toggle_oe_n) |-> ##[TOGGLE_CYC:T_HI] detach_req)
    else $error("no detach after toggle");
  detach_pulse_a: assert property (detach_req |-> power_monitor_out ##1 (!detach_req && power_monitor_out) [*8])
    else $error("detach not while on");
  toggle_req_a: assert property ($fell(toggle_oe_n) |-> power_monitor_out)
    else $error("toggle while off");
endmodule // mss_asserts

// >>> sim/mss_tb_top.sv
// testbench: host and device ends joined, user sides driven
`timescale 1ns/1ps
module mss_tb_top;
  logic sys_clk = 0;
  logic sys_rst = 1;
  logic power_on = 0, soft_shdn_cmd = 0, fast_power_down_cmd = 0, final_done = 0;
  logic req_hard = 0, req_kill = 0, fast_trig = 0, finalizing, detach_sent, busy, module_off;
  logic fast_trig_en = 1;
  int errors = 0, n_tests = 0, cyc = 0, n;
  always #2 sys_clk = ~sys_clk;
  mss_if mss_if_inst ();
  mss_device #(.TOGGLE_CYC(50), .KILL_CYC(20), .FAST_CYC(30)) mss_device_inst (.sys_clk,
    .sys_rst, .pins(mss_if_inst), .power_on, .soft_shdn_cmd, .fast_power_down_cmd,
    .fast_trig_en, .final_done, .finalizing, .detach_sent);
  mss_host #(.TOGGLE_CYC(50), .KILL_CYC(20)) mss_host_inst (.sys_clk, .sys_rst,
    .pins(mss_if_inst), .req_hard, .req_kill, .fast_trig, .busy, .module_off);
  mss_asserts mss_asserts_inst (.sys_clk, .sys_rst, .toggle_oe_n(mss_if_inst.toggle_oe_n),
    .hard_kill_o(mss_if_inst.hard_kill_o), .hard_kill_n_oe_n(mss_if_inst.hard_kill_n_oe_n),
    .trig_gpio(mss_if_inst.trig_gpio), .power_monitor_out(mss_if_inst.power_monitor_out),
    .aux_supply_out(mss_if_inst.aux_supply_out), .detach_req(mss_if_inst.detach_req),
    .fast_trig_en);
  task automatic end_sim;
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s exp %0d seen %0d", nm, exp, seen);
    end
  endtask
  task automatic pulse(ref logic s);
    @(negedge sys_clk) s = 1;
    @(negedge sys_clk) s = 0;
  endtask
  // model: cycles until monitor falls
  task automatic wait_off;
    n = 0;
    while (mss_if_inst.power_monitor_out !== 1'b0 && n < 300) begin
      @(negedge sys_clk);
      n++;
    end
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      end_sim();
    end
  end
  initial begin
    n = $urandom(32'h5d397fec);
    repeat (2) @(negedge sys_clk);
    sys_rst = 0;
    chk("mon_rst", mss_if_inst.power_monitor_out, 0);
    pulse(power_on);
    chk("aux_on", mss_if_inst.aux_supply_out, 1);
    pulse(soft_shdn_cmd);
    repeat (20 + $urandom_range(30)) @(negedge sys_clk);
    chk("fin_soft", {finalizing, detach_sent, mss_if_inst.power_monitor_out}, 7);
    pulse(final_done);
    wait_off();
    chk("off_soft", n < 3, 1);
    pulse(power_on);
    // let the host see the monitor high first
    repeat (4) @(negedge sys_clk);
    pulse(req_hard);
    repeat (100) @(negedge sys_clk);
    chk("fin_hard", {finalizing, detach_sent, busy}, 7);
    pulse(req_hard);
    chk("refuse", mss_if_inst.toggle_oe_n, 1);
    pulse(final_done);
    repeat (8) @(negedge sys_clk);
    chk("off_hard", {module_off, busy, mss_if_inst.aux_supply_out}, 4);
    pulse(power_on);
    @(negedge sys_clk) fast_trig = 1;
    wait_off();
    chk("fast_gpio", n >= 29 && n <= 35, 1);
    fast_trig = 0;
    pulse(power_on);
    pulse(fast_power_down_cmd);
    wait_off();
    chk("fast_cmd", n >= 27 && n <= 33, 1);
    pulse(power_on);
    fast_trig_en = 0;
    @(negedge sys_clk) fast_trig = 1;
    repeat (40) @(negedge sys_clk);
    chk("fast_unarmed", mss_if_inst.power_monitor_out, 1);
    fast_trig = 0;
    fast_trig_en = 1;
    pulse(soft_shdn_cmd);
    repeat (40) @(negedge sys_clk);
    pulse(req_kill);
    wait_off();
    chk("kill", n >= 17 && n <= 28, 1);
    end_sim();
  end
endmodule // mss_tb_top
